// ### rtl/single_wire_uart_node.v
// Single-wire UART node: baud detection, datagram decode, CRC8 and read reply
//
// What this block does
// - Effective node address is base value plus strap offset zero to seven.
// - Strap bit2 adds four, bit1 adds two, bit0 adds one.
// - Register byte MSB zero means read, one means write; low seven bits address.
// - Over 63 bit times between byte start bits resets receive state.
// - Pulse under 16 clocks or CRC error is an error; then 12 idle bits needed.
// - Eight-bit wrapping counter counts accepted writes; reads leave it unchanged.
// - Reply uses the bit time measured on the read request.
// - Reply waits a delay in units of eight bit times; default eight.
// - Reply is sync, 0xFF address, register byte, four data bytes, CRC.
// - Driver is released four bit times after the reply's last bit.
// - Pin is input and searched for datagrams; driven only for a reply.
// - Chain select output is high in reset, then follows its input value; it carries data in ring mode.
// - CRC8 poly x8+x2+x+1, init zero, LSB first over all bytes, last byte.
// - Only datagrams with good CRC and own address are acted on.
// - All three strap pins high selects ring mode.
// - Bytes go LSB first, multi-byte fields highest byte first.
// - Bit time is measured from start edge to falling edge of sync bits 2-3.
// - Each byte has a low start bit and a high stop bit.
`timescale 1ns/100ps
`include "swuart_consts.vh"

module single_wire_uart_node #(
  parameter CNT_W = 16
) (
  input  wire        i_clock,
  input  wire        i_reset_n,
  input  wire        i_data_pin,
  output reg         o_data_pin_out,
  output reg         o_data_pin_oe,
  input  wire        i_strap_address_bit2,
  input  wire        i_strap_address_bit1,
  input  wire        i_strap_address_bit0,
  input  wire [7:0]  i_node_address_base,
  input  wire [3:0]  i_reply_delay_setting,
  input  wire        i_chain_select_value,
  output reg         o_chain_select_output,
  output reg         o_ring_mode,
  output reg         o_wr_strobe,
  output reg  [6:0]  o_wr_addr,
  output reg  [31:0] o_wr_data,
  output reg         o_rd_req,
  output reg  [6:0]  o_rd_addr,
  input  wire [31:0] i_rd_data,
  output reg  [7:0]  o_write_count,
  output reg         o_error
);

  localparam [3:0] S_IDLE    = 4'd0;
  localparam [3:0] S_MEAS    = 4'd1;
  localparam [3:0] S_RXBIT   = 4'd2;
  localparam [3:0] S_GAP     = 4'd3;
  localparam [3:0] S_RECOVER = 4'd4;
  localparam [3:0] S_LOAD    = 4'd5;
  localparam [3:0] S_DELAY   = 4'd6;
  localparam [3:0] S_TX      = 4'd7;
  localparam [3:0] S_HOLD    = 4'd8;

  // Reset bit time trimmed to the counter width on purpose
  localparam [31:0]      RESET_T_FULL = `RESET_BIT_CYCLES;
  localparam [CNT_W-1:0] RESET_T      = RESET_T_FULL[CNT_W-1:0];

  function [7:0] crc_step;
    input [7:0] c;
    input       b;
    begin
      crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `CRC_POLY : 8'h00);
    end
  endfunction

  reg  [3:0]       state;
  reg              pin_d;
  reg  [CNT_W-1:0] meas;
  reg              mid_fall;
  reg  [CNT_W-1:0] bit_t;
  reg  [CNT_W-1:0] good_t;
  reg  [CNT_W-1:0] rx_ph;
  reg  [3:0]       rx_idx;
  reg  [7:0]       rx_sh;
  reg  [2:0]       byte_cnt;
  reg  [7:0]       addr_b;
  reg  [7:0]       reg_b;
  reg  [31:0]      data_sh;
  reg  [7:0]       crc_run;
  reg  [7:0]       crc_prev;
  reg  [CNT_W-1:0] tk;
  reg  [7:0]       bcnt;
  reg              restart;
  reg  [55:0]      frame;
  reg  [9:0]       tx_sh;
  reg  [3:0]       tx_bit;
  reg  [2:0]       tx_byte;
  reg  [7:0]       crc_tx;

  wire             fall      = pin_d & ~i_data_pin;
  wire             rise      = ~pin_d & i_data_pin;
  wire [2:0]       strap     = {i_strap_address_bit2, i_strap_address_bit1, i_strap_address_bit0};
  wire [7:0]       own_addr  = i_node_address_base + {5'd0, strap};
  wire             ring      = &strap;
  wire             tx_phase  = (state == S_DELAY) || (state == S_TX) || (state == S_HOLD);
  wire [CNT_W-1:0] per       = tx_phase ? bit_t : good_t;
  wire             tick      = (tk == {CNT_W{1'b0}});
  wire [CNT_W-1:0] meas_nx   = meas + 1'b1;
  wire             last_byte = (byte_cnt == `READ_LAST_BYTE && !reg_b[`RW_BIT]) || byte_cnt == `WRITE_LAST_BYTE;
  wire [3:0]       dly_units = (i_reply_delay_setting == 4'd0) ? 4'd1 : i_reply_delay_setting;
  wire [7:0]       dly_bits  = {1'b0, dly_units, 3'b000};
  wire [7:0]       crc_sync  = crc_step(crc_step(crc_step(`CRC_INIT, 1'b1), 1'b0), 1'b1);

  // Bit-time ticker shared by gap, recovery, delay, transmit and release timing
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tk   <= {CNT_W{1'b0}};
      bcnt <= 8'd0;
    end else if (restart) begin
      tk   <= per - 1'b1;
      bcnt <= 8'd0;
    end else if (tick) begin
      tk   <= per - 1'b1;
      bcnt <= (bcnt == 8'hFF) ? bcnt : bcnt + 1'b1;
    end else begin
      tk   <= tk - 1'b1;
    end
  end

  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state                 <= S_IDLE;
      pin_d                 <= 1'b1;
      meas                  <= {CNT_W{1'b0}};
      mid_fall              <= 1'b0;
      bit_t                 <= RESET_T;
      good_t                <= RESET_T;
      rx_ph                 <= {CNT_W{1'b0}};
      rx_idx                <= 4'd0;
      rx_sh                 <= 8'd0;
      byte_cnt              <= 3'd0;
      addr_b                <= 8'd0;
      reg_b                 <= 8'd0;
      data_sh               <= 32'h0000_0000;
      crc_run               <= `CRC_INIT;
      crc_prev              <= `CRC_INIT;
      restart               <= 1'b0;
      frame                 <= 56'h00_0000_0000_0000;
      tx_sh                 <= 10'h3FF;
      tx_bit                <= 4'd0;
      tx_byte               <= 3'd0;
      crc_tx                <= `CRC_INIT;
      o_data_pin_out        <= 1'b1;
      o_data_pin_oe         <= 1'b0;
      o_chain_select_output <= 1'b1;
      o_ring_mode           <= 1'b0;
      o_wr_strobe           <= 1'b0;
      o_wr_addr             <= 7'd0;
      o_wr_data             <= 32'h0000_0000;
      o_rd_req              <= 1'b0;
      o_rd_addr             <= 7'd0;
      o_write_count         <= 8'd0;
      o_error               <= 1'b0;
    end else begin
      pin_d       <= i_data_pin;
      restart     <= 1'b0;
      o_wr_strobe <= 1'b0;
      o_rd_req    <= 1'b0;
      o_error     <= 1'b0;
      o_ring_mode <= ring;
      case (state)
        S_IDLE: begin
          if (fall) begin
            meas     <= {CNT_W{1'b0}};
            mid_fall <= 1'b0;
            byte_cnt <= 3'd0;
            restart  <= 1'b1;
            state    <= S_MEAS;
          end
        end
        S_MEAS: begin
          meas <= meas_nx;
          if (rise && meas_nx < `GLITCH_CYCLES) begin
            o_error <= 1'b1;
            restart <= 1'b1;
            state   <= S_RECOVER;
          end else if (&meas) begin
            o_error <= 1'b1;
            restart <= 1'b1;
            state   <= S_RECOVER;
          end else if (fall && !mid_fall) begin
            mid_fall <= 1'b1;
          end else if (fall) begin
            // Sync start edge to bits 2-3 edge spans four bit times
            bit_t   <= meas_nx >> 2;
            rx_ph   <= (meas_nx >> 3) - 1'b1;
            rx_idx  <= 4'd3;
            rx_sh   <= {`SYNC_PRESET, 5'd0};
            crc_run <= crc_sync;
            state   <= S_RXBIT;
          end
        end
        S_RXBIT: begin
          if (rx_ph != {CNT_W{1'b0}}) begin
            rx_ph <= rx_ph - 1'b1;
          end else begin
            rx_ph <= bit_t - 1'b1;
            if (rx_idx != `STOP_INDEX) begin
              rx_sh   <= {i_data_pin, rx_sh[7:1]};
              crc_run <= crc_step(crc_run, i_data_pin);
              rx_idx  <= rx_idx + 1'b1;
            end else if (!i_data_pin) begin
              o_error <= 1'b1;
              restart <= 1'b1;
              state   <= S_RECOVER;
            end else if (last_byte) begin
              if (rx_sh != crc_prev) begin
                o_error <= 1'b1;
                restart <= 1'b1;
                state   <= S_RECOVER;
              end else begin
                good_t <= bit_t;
                state  <= S_IDLE;
                if (addr_b == own_addr && reg_b[`RW_BIT]) begin
                  o_wr_strobe   <= 1'b1;
                  o_wr_addr     <= reg_b[6:0];
                  o_wr_data     <= data_sh;
                  o_write_count <= o_write_count + 1'b1;
                end else if (addr_b == own_addr) begin
                  o_rd_req  <= 1'b1;
                  o_rd_addr <= reg_b[6:0];
                  state     <= S_LOAD;
                end
              end
            end else begin
              if (byte_cnt == 3'd1) addr_b <= rx_sh;
              if (byte_cnt == 3'd2) reg_b <= rx_sh;
              if (byte_cnt >= 3'd3) data_sh <= {data_sh[23:0], rx_sh};
              byte_cnt <= byte_cnt + 1'b1;
              state    <= S_GAP;
            end
          end
        end
        S_GAP: begin
          if (fall) begin
            rx_ph    <= bit_t + (bit_t >> 1) - 1'b1;
            rx_idx   <= 4'd0;
            crc_prev <= crc_run;
            restart  <= 1'b1;
            state    <= S_RXBIT;
          end else if (bcnt > `GAP_BITS) begin
            o_error <= 1'b1;
            restart <= 1'b1;
            state   <= S_RECOVER;
          end
        end
        S_RECOVER: begin
          // Any low level restarts the idle count, so noise keeps the node deaf
          if (!i_data_pin) begin
            restart <= 1'b1;
          end else if (!restart && bcnt >= `RECOVER_BITS) begin
            state <= S_IDLE;
          end
        end
        S_LOAD: begin
          // Register data is sampled in the cycle that the read request pulse is high
          frame   <= {`SYNC_BYTE, `REPLY_ADDR, 1'b0, reg_b[6:0], i_rd_data};
          restart <= 1'b1;
          state   <= S_DELAY;
        end
        S_DELAY: begin
          // Bit count is stale until the pending restart has cleared it
          if (!restart && bcnt >= dly_bits) begin
            tx_sh   <= {1'b1, frame[55:48], 1'b0};
            frame   <= {frame[47:0], 8'h00};
            tx_bit  <= 4'd0;
            tx_byte <= 3'd0;
            crc_tx  <= `CRC_INIT;
            restart <= 1'b1;
            state   <= S_TX;
          end
        end
        S_TX: begin
          if (tick && !restart) begin
            if (tx_bit != `TX_STOP_INDEX) begin
              if (tx_bit != 4'd0 && tx_byte != `TX_LAST_BYTE) crc_tx <= crc_step(crc_tx, tx_sh[0]);
              tx_sh  <= {1'b1, tx_sh[9:1]};
              tx_bit <= tx_bit + 1'b1;
            end else if (tx_byte == `TX_LAST_BYTE) begin
              tx_sh   <= 10'h3FF;
              restart <= 1'b1;
              state   <= S_HOLD;
            end else begin
              tx_sh   <= {1'b1, (tx_byte == 3'd6) ? crc_tx : frame[55:48], 1'b0};
              frame   <= {frame[47:0], 8'h00};
              tx_bit  <= 4'd0;
              tx_byte <= tx_byte + 1'b1;
            end
          end
        end
        S_HOLD: begin
          if (!restart && bcnt >= `RELEASE_BITS) begin
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
      // Driver on the pin only while replying; ring mode sends on the chain output
      o_data_pin_out        <= (state == S_TX) ? tx_sh[0] : 1'b1;
      o_data_pin_oe         <= (state == S_TX || state == S_HOLD) && !ring;
      o_chain_select_output <= ring ? ((state == S_TX) ? tx_sh[0] : 1'b1) : i_chain_select_value;
    end
  end

endmodule // single_wire_uart_node

// ### rtl/swuart_consts.vh
// Constants for the single-wire UART node
`ifndef SWUART_CONSTS_VH
`define SWUART_CONSTS_VH
`define CLK_HZ            40000000
`define MIN_BAUD          9000
`define RESET_BIT_CYCLES  (`CLK_HZ / `MIN_BAUD)
`define GLITCH_CYCLES     16
`define GAP_BITS          63
`define RECOVER_BITS      12
`define RELEASE_BITS      4
`define DELAY_UNIT_SHIFT  3
`define SYNC_BYTE         8'h05
`define SYNC_PRESET       3'b101
`define REPLY_ADDR        8'hFF
`define CRC_POLY          8'h07
`define CRC_INIT          8'h00
`define RW_BIT            7
`define READ_LAST_BYTE    3'd3
`define WRITE_LAST_BYTE   3'd7
`define TX_LAST_BYTE      3'd7
`define STOP_INDEX        4'd8
`define TX_STOP_INDEX     4'd9
`endif

// ### sim/single_wire_uart_node_monitor.sv
// Port-level assertions for the single-wire UART node
`timescale 1ns/100ps
module single_wire_uart_node_monitor (
  input wire       i_clock,
  input wire       i_reset_n,
  input wire       i_strap_address_bit2,
  input wire       i_strap_address_bit1,
  input wire       i_strap_address_bit0,
  input wire       i_chain_select_value,
  input wire       o_data_pin_out,
  input wire       o_data_pin_oe,
  input wire       o_chain_select_output,
  input wire       o_ring_mode,
  input wire       o_wr_strobe,
  input wire       o_rd_req,
  input wire [7:0] o_write_count
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  sequence s_quiet; !o_data_pin_oe [*8]; endsequence
  sequence s_no_strobe; !o_wr_strobe && !o_rd_req; endsequence
  property p_idle_high; !o_data_pin_oe && !o_ring_mode |-> o_data_pin_out; endproperty
  a_idle_high: assert property (p_idle_high) else $error("line low while undriven");
  property p_ring; $past(i_reset_n) |->
    o_ring_mode == $past(i_strap_address_bit2 & i_strap_address_bit1 & i_strap_address_bit0); endproperty
  a_ring: assert property (p_ring) else $error("ring mode wrong");
  property p_chain; $past(i_reset_n) && !o_ring_mode && !$past(o_ring_mode) |->
    o_chain_select_output == $past(i_chain_select_value); endproperty
  a_chain: assert property (p_chain) else $error("chain output wrong");
  property p_count_step; o_wr_strobe |-> o_write_count == $past(o_write_count) + 8'h01; endproperty
  a_count_step: assert property (p_count_step) else $error("count not stepped");
  property p_count_hold; !o_wr_strobe |-> $stable(o_write_count); endproperty
  a_count_hold: assert property (p_count_hold) else $error("count moved");
  property p_wr_pulse; o_wr_strobe |=> s_no_strobe; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  // Shortest legal delay is eight bit times, far above eight cycles
  property p_reply_wait; o_rd_req |=> s_quiet; endproperty
  a_reply_wait: assert property (p_reply_wait) else $error("reply too early");
  property p_release; $fell(o_data_pin_oe) |-> $past(o_data_pin_out, 8); endproperty
  a_release: assert property (p_release) else $error("driver released early");
endmodule  // single_wire_uart_node_monitor

bind single_wire_uart_node single_wire_uart_node_monitor u_monitor (
  .i_clock               (i_clock),
  .i_reset_n             (i_reset_n),
  .i_strap_address_bit2  (i_strap_address_bit2),
  .i_strap_address_bit1  (i_strap_address_bit1),
  .i_strap_address_bit0  (i_strap_address_bit0),
  .i_chain_select_value  (i_chain_select_value),
  .o_data_pin_out        (o_data_pin_out),
  .o_data_pin_oe         (o_data_pin_oe),
  .o_chain_select_output (o_chain_select_output),
  .o_ring_mode           (o_ring_mode),
  .o_wr_strobe           (o_wr_strobe),
  .o_rd_req              (o_rd_req),
  .o_write_count         (o_write_count)
);

// ### sim/host_uart_model.sv
// Host UART model on the shared single-wire line
`timescale 1ns/100ps
module host_uart_model (
  input  wire i_clock,
  input  wire i_line,
  output reg  o_tx
);
  initial o_tx = 1'b1;
  // CRC of the top n bytes, bits LSB first, seed zero
  function automatic [7:0] crc_of(input [63:0] r, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 8 * n; i++)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ r[56 - 8 * (i / 8) + i % 8]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic bit_out(input logic v, input int t);
    o_tx = v;
    repeat (t) @(negedge i_clock);
  endtask
  // Mode 1 flips the CRC low bit, mode 2 leaves it out to stall the frame
  task automatic send(input [63:0] d, input int n, input int t, input int mode);
    logic [7:0] b;
    for (int k = 0; k < n + (mode != 2); k++) begin
      b = (k < n) ? d[63 - 8 * k -: 8] : crc_of(d, n) ^ {7'h00, mode == 1};
      bit_out(1'b0, t);
      for (int i = 0; i < 8; i++)
        bit_out(b[i], t);
      bit_out(1'b1, t);
    end
  endtask
  // Resyncs on each start edge; a hang is left to the bench watchdog
  task automatic recv(output [63:0] r, input int t);
    for (int k = 0; k < 8; k++) begin
      while (i_line)
        @(negedge i_clock);
      repeat (t / 2) @(negedge i_clock);
      for (int i = 0; i < 8; i++) begin
        repeat (t) @(negedge i_clock);
        r[56 - 8 * k + i] = i_line;
      end
      repeat (t) @(negedge i_clock);
    end
  endtask
endmodule  // host_uart_model

// ### sim/tb_single_wire_uart_node.sv
// Self-checking testbench for the single-wire UART node
`timescale 1ns/100ps
module tb_single_wire_uart_node;
  logic        i_clock, i_reset_n, i_chain_select_value;
  logic        i_strap_address_bit2, i_strap_address_bit1, i_strap_address_bit0;
  logic [7:0]  i_node_address_base, own, cnt;
  logic [3:0]  i_reply_delay_setting, rsv;
  logic [6:0]  reg_a;
  logic [31:0] i_rd_data, data;
  logic [63:0] reply, got;
  wire         o_data_pin_out, o_data_pin_oe, o_chain_select_output, o_ring_mode;
  wire         o_wr_strobe, o_rd_req, o_error, host_tx;
  wire  [6:0]  o_wr_addr, o_rd_addr;
  wire  [31:0] o_wr_data;
  wire  [7:0]  o_write_count;
  wire         i_data_pin = o_data_pin_oe ? o_data_pin_out : host_tx;  // Host idles high
  int          err_count, total_checks, errs, e0, t;
  single_wire_uart_node u_dut (
    .i_clock               (i_clock),
    .i_reset_n             (i_reset_n),
    .i_data_pin            (i_data_pin),
    .o_data_pin_out        (o_data_pin_out),
    .o_data_pin_oe         (o_data_pin_oe),
    .i_strap_address_bit2  (i_strap_address_bit2),
    .i_strap_address_bit1  (i_strap_address_bit1),
    .i_strap_address_bit0  (i_strap_address_bit0),
    .i_node_address_base   (i_node_address_base),
    .i_reply_delay_setting (i_reply_delay_setting),
    .i_chain_select_value  (i_chain_select_value),
    .o_chain_select_output (o_chain_select_output),
    .o_ring_mode           (o_ring_mode),
    .o_wr_strobe           (o_wr_strobe),
    .o_wr_addr             (o_wr_addr),
    .o_wr_data             (o_wr_data),
    .o_rd_req              (o_rd_req),
    .o_rd_addr             (o_rd_addr),
    .i_rd_data             (i_rd_data),
    .o_write_count         (o_write_count),
    .o_error               (o_error)
  );
  host_uart_model u_host (.i_clock(i_clock), .i_line(i_data_pin), .o_tx(host_tx));
  // Listens on the chain output, which carries the reply in ring mode
  host_uart_model u_ring (.i_clock(i_clock), .i_line(o_chain_select_output), .o_tx());
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) if (o_error) errs++;
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic frame(input [7:0] a, input logic wr, input int mode);
    rsv = $urandom;
    reg_a = $urandom;
    data = $urandom;
    cnt = o_write_count;
    e0 = errs;
    u_host.send({rsv, 4'h5, a, wr, reg_a, data, 8'h00}, wr ? 7 : 3, t, mode);
    repeat (4) @(negedge i_clock);
  endtask
  initial begin
    void'($urandom(32'h7ad6_3735));
    {i_reset_n, i_strap_address_bit2, i_strap_address_bit1, i_strap_address_bit0} = 4'h0;
    i_node_address_base = $urandom % 240;
    i_reply_delay_setting = 4'h2;
    i_chain_select_value = $urandom;
    i_rd_data = 32'h0000_0000;
    repeat (4) @(negedge i_clock);
    i_reset_n = 1'b1;
    repeat (2) @(negedge i_clock);
    check("chain", o_chain_select_output, i_chain_select_value);
    t = 16;
    for (int s = 0; s < 7; s++) begin
      {i_strap_address_bit2, i_strap_address_bit1, i_strap_address_bit0} = s[2:0];
      own = i_node_address_base + {5'h00, s[2:0]};
      frame(own, 1'b1, 0);
      check("wr_addr", o_wr_addr, reg_a);
      check("wr_data", o_wr_data, data);
      check("count", o_write_count, 8'(cnt + 8'h01));
    end
    $display("test writes done");
    frame(own + 8'h01, 1'b1, 0);
    check("count", o_write_count, cnt);
    check("errors", errs, e0);
    frame(own, 1'b1, 1);
    check("count", o_write_count, cnt);
    check("errors", errs, e0 + 1);
    frame(own, 1'b1, 0);
    check("count", o_write_count, cnt);
    repeat (13 * t) @(negedge i_clock);
    frame(own, 1'b1, 0);
    check("count", o_write_count, 8'(cnt + 8'h01));
    e0 = errs;
    u_host.bit_out(1'b0, 8);
    u_host.bit_out(1'b1, 13 * t);
    check("errors", errs, e0 + 1);
    e0 = errs;
    u_host.send({8'h05, own, 48'h0}, 2, t, 2);
    repeat (70 * t) @(negedge i_clock);
    check("errors", errs, e0 + 1);
    repeat (13 * t) @(negedge i_clock);
    $display("test refusals done");
    for (int i = 0; i < 4; i++) begin
      t = 17 + $urandom % 40;
      i_reply_delay_setting = i[3:0];
      i_rd_data = $urandom;
      frame(own, 1'b0, 0);
      check("rd_addr", o_rd_addr, reg_a);
      check("count", o_write_count, cnt);
      reply = {8'h05, 8'hFF, 1'b0, reg_a, i_rd_data, 8'h00};
      reply[7:0] = u_host.crc_of(reply, 7);
      u_host.recv(got, t);
      check("reply", got, reply);
      repeat (3 * t) @(negedge i_clock);
      check("oe_held", o_data_pin_oe, 1'b1);
      repeat (3 * t) @(negedge i_clock);
      check("oe_off", o_data_pin_oe, 1'b0);
    end
    $display("test reads done");
    {i_strap_address_bit2, i_strap_address_bit1, i_strap_address_bit0} = 3'h7;
    repeat (2) @(negedge i_clock);
    check("ring", o_ring_mode, 1'b1);
    check("chain_idle", o_chain_select_output, 1'b1);
    frame(i_node_address_base + 8'h07, 1'b0, 0);
    reply = {8'h05, 8'hFF, 1'b0, reg_a, i_rd_data, 8'h00};
    reply[7:0] = u_host.crc_of(reply, 7);
    u_ring.recv(got, t);
    check("ring_reply", got, reply);
    repeat (3 * t) @(negedge i_clock);
    check("oe_ring", o_data_pin_oe, 1'b0);
    $display("test ring mode done");
    end_of_test;
  end
  // Planned run is near 50k cycles
  initial begin
    repeat (80000) @(posedge i_clock);
    err_count++;
    end_of_test;
  end
endmodule  // tb_single_wire_uart_node
